// ==== common/bpm_pkg.sv ====
// Shared constants and types for the battery power-mode controller and its host end
package bpm_pkg;
  // Subcommand codes carried over the link
  localparam logic [15:0] SUBCMD_SHUTDOWN      = 16'h0010;
  localparam logic [15:0] SUBCMD_DEEP_IDLE     = 16'h000f;
  localparam logic [15:0] SUBCMD_LEAVE_IDLE    = 16'h000e;
  localparam logic [15:0] SUBCMD_RESET         = 16'h0012;
  localparam logic [15:0] SUBCMD_SLEEP_ALLOW   = 16'h0099;
  localparam logic [15:0] SUBCMD_SLEEP_FORBID  = 16'h009a;
  localparam logic [15:0] SUBCMD_SWITCH_AUTO   = 16'h0022;
  // Status word addresses and bit positions
  localparam logic [7:0]  ADDR_BATT_STATUS     = 8'h12;
  localparam logic [7:0]  ADDR_ALARM_STATUS    = 8'h62;
  localparam int          BIT_BATT_SLEEP       = 15;
  localparam int          BIT_BATT_SWITCH_EN   = 8;
  localparam int          BIT_ALARM_SLEEP      = 2;
  localparam int          BIT_ALARM_WAKE       = 3;
  // Timing in link clock terms (48 ns period)
  localparam int          LINK_PERIOD_NS       = 48;
  localparam int          WAKE_SAMPLE_US       = 2440;
  localparam int          OSC_HOLD_US          = 25000;
  localparam int          WINDOW_MS            = 4000;
  localparam int          REENTRY_MS           = 10000;
  localparam int          PWRDN_WAIT_MS        = 10000;
  localparam int          WAKE_SAMPLE_CYC      = (WAKE_SAMPLE_US * 1000) / LINK_PERIOD_NS;
  localparam int          OSC_HOLD_CYC         = (OSC_HOLD_US * 1000) / LINK_PERIOD_NS;
  localparam longint      WINDOW_CYC           = (64'(WINDOW_MS) * 1000000) / LINK_PERIOD_NS;
  localparam longint      REENTRY_CYC          = (64'(REENTRY_MS) * 1000000) / LINK_PERIOD_NS;
  localparam longint      PWRDN_WAIT_CYC       = (64'(PWRDN_WAIT_MS) * 1000000) / LINK_PERIOD_NS;
  // Host divider: link clock = ref_clk / (2 * LINK_DIV)
  localparam int          LINK_DIV             = 1;
  // Operating modes
  typedef enum logic [2:0] {
    BPM_FULL     = 3'b000,
    BPM_LOWPWR   = 3'b001,
    BPM_IDLE     = 3'b010,
    BPM_STARTUP  = 3'b011,
    BPM_PD_WAIT  = 3'b100,
    BPM_SOFT_PD  = 3'b101,
    BPM_OFF      = 3'b110
  } bpm_mode_t;
endpackage : bpm_pkg

// ==== common/bpm_if.sv ====
// Link between host processor end and the power-mode device end
interface bpm_if;
  logic        link_clk;      // Link clock, made by the host
  logic        cmd_valid;     // Subcommand strobe, one link cycle
  logic [15:0] cmd_code;      // Subcommand code
  logic [15:0] batt_status;   // Battery status word
  logic [7:0]  alarm_status;  // Alarm status byte
  logic [2:0]  mode;          // Present operating mode
  modport host (output link_clk, output cmd_valid, output cmd_code,
                input batt_status, input alarm_status, input mode);
  modport dev  (input link_clk, input cmd_valid, input cmd_code,
                output batt_status, output alarm_status, output mode);
endinterface : bpm_if

// ==== rtl/bpm_device.sv ====
// Power-mode sequencer of the battery monitor, clocked by the link clock
// Contract
// - slow-loop setting lowers full-rate measurement rate
// - enter low power below sleep current
// - power-up bit, then allow/forbid subcommands
// - status bit and entry/wake alarm bits
// - comparators on, ADC each voltage-time interval
// - wake comparator decides without coulomb result
// - wake sample every 2.44 ms
// - exit on alert, current, forbid subcommand
// - block low-power re-entry ten seconds
// - deep idle: switches, protections, measurements off
// - deep idle on second command in window
// - leave idle on subcommand or pin edge
// - regulator reset or overtemp gives power-down
// - startup sequence before resuming full rate
// - regulator kept, oscillator wakes 25 ms
// - double power-down subcommand starts sequence
// - automatic power-down on low voltage, temperature
// - ten second wait, third command skips
// - full rate, forbid sleep, clear flags; code runs no ADC in the power-down wait
// - recovery ignored, host may cancel
// - hardware overtemperature with config starts power-down
// - soft power-down while wake condition present
// - timer running keeps oscillator on
module bpm_device
  import bpm_pkg::*;
#(
  parameter longint WINDOW_CYCLES  = WINDOW_CYC,     // Double-command window
  parameter longint REENTRY_CYCLES = REENTRY_CYC,    // Low-power re-entry block
  parameter longint PWRDN_CYCLES   = PWRDN_WAIT_CYC, // Power-down wait
  parameter int     OSC_CYCLES     = OSC_HOLD_CYC,   // Oscillator hold after traffic
  parameter int     SAMPLE_CYCLES  = WAKE_SAMPLE_CYC // Wake comparator period
) (
  bpm_if.dev         lnk,
  input  wire logic  rst_n,
  input  wire logic  sleep_cfg,           // Power-up low-power permission
  input  wire logic  loop_slow_cfg,       // Slow measurement loop
  input  wire logic  idle_osc_off_cfg,    // Oscillator off in deep idle
  input  wire logic  overtemp_powerdown_cfg, // Hardware overtemp starts power-down
  input  wire logic  coulomb_avail,       // Coulomb current result available
  input  wire logic  below_sleep_current, // Coulomb result under sleep threshold
  input  wire logic  wake_comp_above,     // Wake comparator over threshold
  input  wire logic  protection_alert,    // Any protection alert
  input  wire logic  low_voltage,         // Stack or lowest cell under threshold
  input  wire logic  int_overtemp,        // Internal temperature over threshold
  input  wire logic  int_temp_cfg,        // Temperature power-down enabled
  input  wire logic  hw_overtemp,         // Hardware die overtemperature
  input  wire logic  core_por,            // Core regulator power-on-reset
  input  wire logic  thermistor_pin,      // Wake pin, asynchronous
  input  wire logic  bottom_cell_sense_pin, // Wake pin, asynchronous
  input  wire logic  prog_timer_run,      // Programmable timer running
  input  wire logic  startup_done,        // Startup measurements evaluated
  input  wire logic  meas_cycle_done,     // One low-power measurement cycle done
  output logic       adc_enable,          // ADC measurement pulse enable
  output logic       slow_loop,           // Reduced measurement rate
  output logic       comparators_on,      // Comparator protections active
  output logic       switches_allowed,    // Protection switches may be on
  output logic       discharge_switch_block, // Forced discharge off
  output logic       charge_switch_block,    // Forced charge off
  output logic       osc_on,              // Slow oscillator powered
  output logic       aux_regulator_output_hold,         // Aux regulator output keeps state
  output logic       startup_run,         // Run startup sequence
  output logic       power_off            // Full power-down
);
  bpm_mode_t   mode, next_mode;          // Present and next mode
  logic        sleep_allow;              // Low-power permitted
  logic        sleep_cfg_taken;          // Power-up bit captured
  logic        autonomous_switch_enable_flag; // Switch autonomy flag
  logic        alarm_sleep, alarm_wake;  // Entry and wake alarms
  logic [63:0] idle_win, pd_win;         // Window counters
  logic [63:0] reentry_cnt, pd_cnt;      // Block and wait counters
  logic [31:0] osc_cnt, samp_cnt, vt_cnt;// Oscillator, sample, interval counters
  logic [1:0]  ts_sync, vc_sync;         // Pin synchronisers
  logic        ts_q, vc_q;               // Previous synchronised pin levels
  logic        pd_count_two;             // Power-down armed once
  logic        lp_exit_pending;          // Current exit waiting measurement

  // Decoded commands
  wire cmd_idle   = lnk.cmd_valid && lnk.cmd_code == SUBCMD_DEEP_IDLE;
  wire cmd_leave  = lnk.cmd_valid && lnk.cmd_code == SUBCMD_LEAVE_IDLE;
  wire cmd_pd     = lnk.cmd_valid && lnk.cmd_code == SUBCMD_SHUTDOWN;
  wire cmd_reset  = lnk.cmd_valid && lnk.cmd_code == SUBCMD_RESET;
  wire cmd_allow  = lnk.cmd_valid && lnk.cmd_code == SUBCMD_SLEEP_ALLOW;
  wire cmd_forbid = lnk.cmd_valid && lnk.cmd_code == SUBCMD_SLEEP_FORBID;
  wire cmd_auto   = lnk.cmd_valid && lnk.cmd_code == SUBCMD_SWITCH_AUTO;
  // Window open flags
  wire idle_open  = idle_win != 64'h0;
  wire pd_open    = pd_win != 64'h0;
  wire idle_go    = cmd_idle && idle_open;
  wire pd_go      = cmd_pd && pd_open && !pd_count_two;
  // Pin rising edges, from second sync stage only
  wire pin_rise   = (ts_sync[1] && !ts_q) || (vc_sync[1] && !vc_q);
  wire wake_level = ts_sync[1] || vc_sync[1];
  wire relax      = coulomb_avail ? below_sleep_current : !wake_comp_above;
  wire measuring  = mode == BPM_FULL || mode == BPM_LOWPWR;
  wire auto_pd    = measuring && (low_voltage || (int_temp_cfg && int_overtemp));
  wire hw_pd      = overtemp_powerdown_cfg && hw_overtemp && mode != BPM_IDLE;
  wire pd_start   = (pd_go || auto_pd || hw_pd) && mode != BPM_PD_WAIT
                    && mode != BPM_SOFT_PD && mode != BPM_OFF;
  wire samp_tick  = samp_cnt == 32'h0;
  wire cancel     = cmd_leave || cmd_reset;

  // Synchronise wake pins
  always_ff @(posedge lnk.link_clk) begin
    ts_sync <= {ts_sync[0], thermistor_pin};
    vc_sync <= {vc_sync[0], bottom_cell_sense_pin};
    ts_q    <= ts_sync[1];
    vc_q    <= vc_sync[1];
  end

  // Mode transitions
  always_comb begin
    next_mode = mode;
    case (mode)
      BPM_FULL: begin
        if (pd_start) next_mode = BPM_PD_WAIT;
        else if (idle_go) next_mode = BPM_IDLE;
        else if (sleep_allow && relax && reentry_cnt == 64'h0) next_mode = BPM_LOWPWR;
      end
      BPM_LOWPWR: begin
        // power-down goes straight to the wait, which runs no ADC
        if (pd_start) next_mode = BPM_PD_WAIT;
        else if (idle_go) next_mode = BPM_IDLE;
        // alert or forbid exits at once
        else if (protection_alert || cmd_forbid) next_mode = BPM_FULL;
        else if (lp_exit_pending && meas_cycle_done) next_mode = BPM_FULL;
      end
      BPM_IDLE: begin
        if (core_por || hw_overtemp) next_mode = BPM_OFF;
        else if (pd_go) next_mode = BPM_PD_WAIT;
        // only leave command or pin edge go to startup
        else if (cmd_leave || pin_rise) next_mode = BPM_STARTUP;
      end
      BPM_STARTUP: begin
        if (startup_done) next_mode = BPM_FULL;
      end
      BPM_PD_WAIT: begin
        if (cancel) next_mode = BPM_STARTUP;
        else if (pd_cnt == 64'h0 || (cmd_pd && pd_count_two)) next_mode = BPM_SOFT_PD;
      end
      BPM_SOFT_PD: begin
        if (cmd_leave) next_mode = BPM_STARTUP;
        else if (!wake_level) next_mode = BPM_OFF;
      end
      default: next_mode = BPM_OFF;
    endcase
  end

  // Mode register and permissions
  always_ff @(posedge lnk.link_clk) begin
    if (!rst_n) begin
      mode                          <= BPM_STARTUP;
      sleep_allow                   <= 1'b0;
      sleep_cfg_taken               <= 1'b0;
      autonomous_switch_enable_flag <= 1'b1;
      discharge_switch_block        <= 1'b0;
      charge_switch_block           <= 1'b0;
      pd_count_two                  <= 1'b0;
    end else begin
      mode <= next_mode;
      // power-up bit captured once after reset
      if (!sleep_cfg_taken) begin
        sleep_allow     <= sleep_cfg;
        sleep_cfg_taken <= 1'b1;
      end else if (pd_start) sleep_allow <= 1'b0;
      else if (cmd_forbid) sleep_allow <= 1'b0;
      else if (cmd_allow) sleep_allow <= 1'b1;
      // clear autonomy flag, block switches from idle
      if (pd_start) begin
        autonomous_switch_enable_flag <= 1'b0;
        pd_count_two <= 1'b1;
        if (mode == BPM_IDLE) begin
          discharge_switch_block <= 1'b1;
          charge_switch_block    <= 1'b1;
        end
      end else if (cmd_auto) autonomous_switch_enable_flag <= 1'b1;
      if (next_mode == BPM_STARTUP && (mode == BPM_PD_WAIT || mode == BPM_SOFT_PD)) begin
        // Restart with default settings
        pd_count_two                  <= 1'b0;
        autonomous_switch_enable_flag <= 1'b1;
        discharge_switch_block        <= 1'b0;
        charge_switch_block           <= 1'b0;
        sleep_allow                   <= sleep_cfg;
      end
    end
  end

  // Windows, delays and wake sampling
  always_ff @(posedge lnk.link_clk) begin
    if (!rst_n) begin
      idle_win <= 64'h0; pd_win <= 64'h0; reentry_cnt <= 64'h0; pd_cnt <= 64'h0;
      samp_cnt <= 32'h0; lp_exit_pending <= 1'b0;
      alarm_sleep <= 1'b0; alarm_wake <= 1'b0;
    end else begin
      // expired or first command opens window
      if (cmd_idle) idle_win <= idle_open ? 64'h0 : WINDOW_CYCLES;
      else if (idle_open) idle_win <= idle_win - 64'h1;
      if (cmd_pd) pd_win <= pd_open ? 64'h0 : WINDOW_CYCLES;
      else if (pd_open) pd_win <= pd_win - 64'h1;
      if (mode == BPM_LOWPWR && next_mode == BPM_FULL) reentry_cnt <= REENTRY_CYCLES;
      else if (reentry_cnt != 64'h0) reentry_cnt <= reentry_cnt - 64'h1;
      if (pd_start) pd_cnt <= PWRDN_CYCLES;
      else if (pd_cnt != 64'h0) pd_cnt <= pd_cnt - 64'h1;
      if (mode != BPM_LOWPWR || samp_tick) samp_cnt <= 32'(SAMPLE_CYCLES - 1);
      else samp_cnt <= samp_cnt - 32'h1;
      if (mode != BPM_LOWPWR) lp_exit_pending <= 1'b0;
      else if (samp_tick && wake_comp_above) lp_exit_pending <= 1'b1;
      // alarms, each set on its transition, cleared by the opposite one
      alarm_sleep <= (mode != BPM_LOWPWR && next_mode == BPM_LOWPWR) ||
                     (alarm_sleep && !(mode == BPM_LOWPWR && next_mode == BPM_FULL));
      alarm_wake  <= (mode == BPM_LOWPWR && next_mode == BPM_FULL) ||
                     (alarm_wake && !(mode != BPM_LOWPWR && next_mode == BPM_LOWPWR));
    end
  end

  // Oscillator hold after traffic and voltage-time interval
  always_ff @(posedge lnk.link_clk) begin
    if (!rst_n) begin
      osc_cnt <= 32'h0;
      vt_cnt  <= 32'h0;
    end else begin
      if (lnk.cmd_valid) osc_cnt <= 32'(OSC_CYCLES);
      else if (osc_cnt != 32'h0) osc_cnt <= osc_cnt - 32'h1;
      // interval uses wake sample tick as base
      if (mode != BPM_LOWPWR) vt_cnt <= 32'h0;
      else if (samp_tick) vt_cnt <= vt_cnt + 32'h1;
    end
  end

  // Outputs from mode
  always_ff @(posedge lnk.link_clk) begin
    if (!rst_n) begin
      adc_enable <= 1'b0; slow_loop <= 1'b0; comparators_on <= 1'b0;
      switches_allowed <= 1'b0; osc_on <= 1'b1; aux_regulator_output_hold <= 1'b0;
      startup_run <= 1'b0; power_off <= 1'b0;
    end else begin
      // low-power ADC only on interval tick
      adc_enable     <= mode == BPM_FULL || (mode == BPM_LOWPWR && samp_tick && vt_cnt[3:0] == 4'h0);
      slow_loop      <= mode == BPM_FULL && loop_slow_cfg;
      comparators_on <= measuring || mode == BPM_PD_WAIT;
      switches_allowed <= measuring || (mode == BPM_PD_WAIT && pd_cnt != 64'h0);
      osc_on         <= mode != BPM_IDLE || !idle_osc_off_cfg || prog_timer_run || osc_cnt != 32'h0;
      aux_regulator_output_hold    <= mode == BPM_IDLE;
      startup_run    <= mode == BPM_STARTUP;
      power_off      <= mode == BPM_OFF;
    end
  end

  // Status back to the host
  assign lnk.mode         = mode;
  assign lnk.batt_status  = 16'((mode == BPM_LOWPWR) << BIT_BATT_SLEEP) |
                            16'(autonomous_switch_enable_flag << BIT_BATT_SWITCH_EN);
  assign lnk.alarm_status = 8'(alarm_sleep << BIT_ALARM_SLEEP) | 8'(alarm_wake << BIT_ALARM_WAKE);
endmodule : bpm_device

// ==== rtl/bpm_host.sv ====
// Host end: makes the link clock and sends subcommands across the link
module bpm_host
  import bpm_pkg::*;
#(
  parameter int DIV = LINK_DIV   // Half period of link clock in ref_clk cycles
) (
  bpm_if.host        lnk,
  input  wire logic  ref_clk,
  input  wire logic  rst_n,
  input  wire logic  req_valid,   // User subcommand request
  input  wire logic [15:0] req_code, // Subcommand code
  output logic       req_ready,   // Request may be taken
  output logic       low_power,   // Device in low-power mode
  output logic [2:0] dev_mode     // Device mode, synchronised
);
  logic [7:0]  div_cnt;           // Clock divider
  logic        clk_q;             // Link clock level
  logic        busy;              // Command waiting for link edge
  logic [15:0] code_q;            // Held code
  logic        issue;             // Strobe high for one link period
  logic [2:0]  mode_s1, mode_s2;  // Mode synchroniser
  logic [2:0]  mode_q;            // Mode word taken once two samples agree
  logic        lp_s1, lp_s2;      // Low-power bit synchroniser

  // Falling edge about to occur on the link clock
  wire fall_next = clk_q && div_cnt == 8'(DIV - 1);
  assign req_ready = !busy && !issue;

  // host issues each subcommand as one strobe
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      div_cnt <= 8'h0; clk_q <= 1'b0; busy <= 1'b0; code_q <= 16'h0; issue <= 1'b0;
    end else begin
      if (div_cnt == 8'(DIV - 1)) begin
        div_cnt <= 8'h0;
        clk_q   <= !clk_q;
      end else div_cnt <= div_cnt + 8'h1;
      if (req_valid && req_ready) begin
        busy   <= 1'b1;
        code_q <= req_code;
      end
      // Strobe spans fall to fall, so the rising edge that takes it never
      // races its own removal
      if (busy && fall_next) begin
        issue <= 1'b1;
        busy  <= 1'b0;
      end else if (issue && fall_next) issue <= 1'b0;
    end
  end

  // Status synchroniser from link domain
  always_ff @(posedge ref_clk) begin
    mode_s1 <= lnk.mode;
    mode_s2 <= mode_s1;
    // Word taken only when stable, so a sample caught mid-change never shows
    if (mode_s1 == mode_s2) mode_q <= mode_s2;
    lp_s1   <= lnk.batt_status[BIT_BATT_SLEEP];
    lp_s2   <= lp_s1;
  end

  assign lnk.link_clk  = clk_q;
  assign lnk.cmd_valid = issue;
  assign lnk.cmd_code  = code_q;
  assign low_power     = lp_s2;
  assign dev_mode      = mode_q;
endmodule : bpm_host

// ==== verif/bpm_checker.sv ====
// Concurrent checks on the link joining the host end and the device end
module bpm_checker
  import bpm_pkg::*;
(
  input wire logic        link_clk,
  input wire logic        rst_n,
  input wire logic        cmd_valid,
  input wire logic [15:0] cmd_code,
  input wire logic [15:0] batt_status,
  input wire logic [7:0]  alarm_status,
  input wire logic [2:0]  mode
);
  logic [7:0] since_idle;  // Link cycles since the last deep idle subcommand
  wire        idle_cmd = cmd_valid && (cmd_code == SUBCMD_DEEP_IDLE);  // Deep idle seen
  wire        in_low   = (mode == BPM_LOWPWR);                         // Low-power mode
  default clocking cb @(posedge link_clk); endclocking
  default disable iff (!rst_n);
  // Saturating count, so a stale command never looks recent
  always_ff @(posedge link_clk) begin
    if (!rst_n) begin
      since_idle <= 8'hff;
    end else if (idle_cmd) begin
      since_idle <= 8'h00;
    end else if (since_idle != 8'hff) begin
      since_idle <= since_idle + 8'h01;
    end
  end
  chk_idle_after_cmd: assert property ($rose(mode == BPM_IDLE) |-> since_idle < 8'h08)
    else $error("deep idle entered without a recent subcommand");
  chk_sleep_status_bit: assert property ($stable(in_low) |-> batt_status[BIT_BATT_SLEEP] == in_low)
    else $error("low-power status bit disagrees with mode");
  chk_entry_alarm_bit: assert property ($rose(in_low) |-> ##[0:2] alarm_status[BIT_ALARM_SLEEP])
    else $error("no entry alarm on low-power entry");
  chk_wake_alarm_bit: assert property ($fell(in_low) |-> ##[0:2] alarm_status[BIT_ALARM_WAKE])
    else $error("no wake alarm on low-power exit");
  chk_forbid_exit_low: assert property (cmd_valid && cmd_code == SUBCMD_SLEEP_FORBID && in_low
    |-> ##[1:4] mode == BPM_FULL) else $error("forbid subcommand did not end low power");
  chk_leave_idle_cmd: assert property (cmd_valid && cmd_code == SUBCMD_LEAVE_IDLE && mode == BPM_IDLE
    |-> ##[1:4] mode == BPM_STARTUP) else $error("leave subcommand did not end deep idle");
  chk_idle_via_startup: assert property ($past(mode) == BPM_IDLE && mode != BPM_IDLE
    |-> !(mode inside {BPM_FULL, BPM_LOWPWR})) else $error("deep idle skipped startup");
  chk_pd_clears_flag: assert property ($rose(mode == BPM_PD_WAIT)
    |-> ##[0:2] !batt_status[BIT_BATT_SWITCH_EN]) else $error("autonomy flag kept in power-down");
  chk_pd_no_sleep: assert property (mode == BPM_PD_WAIT |=> mode != BPM_LOWPWR)
    else $error("low power entered during power-down wait");
  chk_strobe_single: assert property (cmd_valid |=> !cmd_valid)
    else $error("subcommand strobe longer than one link cycle");
endmodule : bpm_checker

// ==== verif/tb.sv ====
// Self-checking bench: host end and device end joined across the link
module tb
  import bpm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic [15:0] code; int n; logic [2:0] exp;} bpm_row_t;  // Command, count, mode
  logic        ref_clk, host_rst_n, dev_rst_n, req_valid, req_ready, low_power;
  logic [15:0] req_code;
  logic [2:0]  dev_mode;
  logic        sleep_cfg, loop_slow_cfg, idle_osc_off_cfg, overtemp_powerdown_cfg, coulomb_avail;
  logic        below_sleep_current, wake_comp_above, protection_alert, low_voltage, hw_overtemp;
  logic        core_por, thermistor_pin, bottom_cell_sense_pin, startup_done, meas_cycle_done;
  logic        adc_enable, slow_loop, comparators_on, switches_allowed, discharge_switch_block;
  logic        charge_switch_block, osc_on, aux_regulator_output_hold, startup_run, power_off;
  logic        int_overtemp, int_temp_cfg, prog_timer_run;
  int          n_errors, n_checks;  // Mismatches and comparisons
  // Ordinary walk through the modes, each row from where the last left off
  bpm_row_t rows [8] = '{'{SUBCMD_SLEEP_ALLOW, 1, BPM_LOWPWR}, '{SUBCMD_SLEEP_FORBID, 1, BPM_FULL},
    '{SUBCMD_DEEP_IDLE, 2, BPM_IDLE}, '{16'h0033, 1, BPM_IDLE}, '{SUBCMD_LEAVE_IDLE, 1, BPM_FULL},
    '{SUBCMD_SHUTDOWN, 2, BPM_PD_WAIT}, '{SUBCMD_RESET, 1, BPM_FULL}, '{SUBCMD_SHUTDOWN, 3, BPM_OFF}};
  bpm_if lnk ();
  bpm_host bpm_host_i (.lnk(lnk), .ref_clk(ref_clk), .rst_n(host_rst_n), .req_valid(req_valid),
    .req_code(req_code), .req_ready(req_ready), .low_power(low_power), .dev_mode(dev_mode));
  // Shortened counts keep the run small
  bpm_device #(.WINDOW_CYCLES(50), .REENTRY_CYCLES(50), .PWRDN_CYCLES(50), .OSC_CYCLES(20),
    .SAMPLE_CYCLES(4)) bpm_device_i (.lnk(lnk), .rst_n(dev_rst_n), .sleep_cfg(sleep_cfg),
    .loop_slow_cfg(loop_slow_cfg), .idle_osc_off_cfg(idle_osc_off_cfg),
    .overtemp_powerdown_cfg(overtemp_powerdown_cfg), .coulomb_avail(coulomb_avail),
    .below_sleep_current(below_sleep_current), .wake_comp_above(wake_comp_above),
    .protection_alert(protection_alert), .low_voltage(low_voltage), .int_overtemp(int_overtemp),
    .int_temp_cfg(int_temp_cfg), .hw_overtemp(hw_overtemp), .core_por(core_por),
    .thermistor_pin(thermistor_pin), .bottom_cell_sense_pin(bottom_cell_sense_pin),
    .prog_timer_run(prog_timer_run), .startup_done(startup_done),
    .meas_cycle_done(meas_cycle_done),
    .adc_enable(adc_enable), .slow_loop(slow_loop), .comparators_on(comparators_on),
    .switches_allowed(switches_allowed), .discharge_switch_block(discharge_switch_block),
    .charge_switch_block(charge_switch_block), .osc_on(osc_on), .aux_regulator_output_hold(aux_regulator_output_hold),
    .startup_run(startup_run), .power_off(power_off));
  bpm_checker bpm_checker_i (.link_clk(lnk.link_clk), .rst_n(dev_rst_n),
    .cmd_valid(lnk.cmd_valid), .cmd_code(lnk.cmd_code), .batt_status(lnk.batt_status),
    .alarm_status(lnk.alarm_status), .mode(lnk.mode));
  // Reference clock, 25 ns
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude
  task automatic chk(input string what, input logic [2:0] exp, input logic [2:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chk
  // Hold the request until the edge that takes it, then leave link spacing
  task automatic send(input logic [15:0] c);
    int k;
    k = 0;
    req_code = c;
    req_valid = 1'b1;
    @(negedge ref_clk);
    while (req_ready !== 1'b1 && k < 100) begin
      @(negedge ref_clk);
      k++;
    end
    if (k == 100) n_errors++;
    @(posedge ref_clk);
    #2 req_valid = 1'b0;
    repeat (8) @(posedge ref_clk);
    #2;
  endtask : send
  // Send a command n times, let it settle, then compare the mode and its side effects
  task automatic step(input logic [15:0] c, input int n, input logic [2:0] exp);
    for (int i = 0; i < n; i++) send(c);
    repeat (24) @(posedge ref_clk);
    #2 chk("dev_mode", exp, dev_mode);
    if (exp == BPM_IDLE) begin
      chk("switches_allowed", 3'h0, {2'h0, switches_allowed});
      chk("comparators_on", 3'h0, {2'h0, comparators_on});
      chk("aux_regulator_output_hold", 3'h1, {2'h0, aux_regulator_output_hold});
      chk("osc_on", 3'h1, {2'h0, osc_on});
    end
    if (exp == BPM_LOWPWR) begin
      chk("comparators_on", 3'h1, {2'h0, comparators_on});
      chk("low_power", 3'h1, {2'h0, low_power});
    end
    if (exp == BPM_FULL) chk("slow_loop", {2'h0, loop_slow_cfg}, {2'h0, slow_loop});
    if (exp == BPM_OFF) chk("power_off", 3'h1, {2'h0, power_off});
  endtask : step
  // Host released first so the link clock runs while the device is still held
  task automatic do_reset();
    host_rst_n = 1'b0;
    dev_rst_n = 1'b0;
    repeat (12) @(posedge ref_clk);
    #2 host_rst_n = 1'b1;
    repeat (12) @(posedge ref_clk);
    #2 dev_rst_n = 1'b1;
    repeat (8) @(posedge ref_clk);
    #2;
  endtask : do_reset
  // Watchdog, well beyond the expected few thousand cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    conclude();
  end
  initial begin
    {req_valid, sleep_cfg, loop_slow_cfg, idle_osc_off_cfg, overtemp_powerdown_cfg} = '0;
    {wake_comp_above, protection_alert, low_voltage, hw_overtemp, core_por} = '0;
    {thermistor_pin, bottom_cell_sense_pin, int_overtemp, int_temp_cfg, prog_timer_run} = '0;
    {coulomb_avail, below_sleep_current, startup_done, meas_cycle_done} = 4'hf;
    req_code = 16'h0000;
    n_errors = 0;
    n_checks = 0;
    do_reset();
    for (int i = 0; i < 8; i++) step(rows[i].code, rows[i].n, rows[i].exp);
    $display("table walk done");
    {startup_done, loop_slow_cfg} = 2'h1;
    do_reset();
    chk("mode after reset", BPM_STARTUP, dev_mode);
    chk("startup_run", 3'h1, {2'h0, startup_run});
    chk("autonomy flag", 3'h1, {2'h0, lnk.batt_status[BIT_BATT_SWITCH_EN]});
    startup_done = 1'b1;
    step(16'h0000, 0, BPM_FULL);
    step(SUBCMD_SLEEP_ALLOW, 1, BPM_LOWPWR);
    wake_comp_above = 1'b1;
    step(16'h0000, 0, BPM_FULL);
    wake_comp_above = 1'b0;
    step(SUBCMD_SLEEP_ALLOW, 1, BPM_FULL);
    repeat (100) @(posedge ref_clk);
    #2 step(16'h0000, 0, BPM_LOWPWR);
    step(SUBCMD_SLEEP_FORBID, 1, BPM_FULL);
    send(SUBCMD_DEEP_IDLE);
    repeat (300) @(posedge ref_clk);
    #2 step(SUBCMD_DEEP_IDLE, 1, BPM_FULL);
    step(SUBCMD_DEEP_IDLE, 1, BPM_IDLE);
    {idle_osc_off_cfg, prog_timer_run} = 2'h3;
    repeat (60) @(posedge ref_clk);
    #2 chk("osc_on", 3'h1, {2'h0, osc_on});
    prog_timer_run = 1'b0;
    repeat (4) @(posedge ref_clk);
    #2 chk("osc_on", 3'h0, {2'h0, osc_on});
    step(SUBCMD_SLEEP_FORBID, 1, BPM_IDLE);
    thermistor_pin = 1'b1;
    step(16'h0000, 0, BPM_FULL);
    step(SUBCMD_SHUTDOWN, 3, BPM_SOFT_PD);
    thermistor_pin = 1'b0;
    step(16'h0000, 0, BPM_OFF);
    $display("window and wake tests done");
    do_reset();
    step(SUBCMD_DEEP_IDLE, 2, BPM_IDLE);
    core_por = 1'b1;
    step(16'h0000, 0, BPM_OFF);
    core_por = 1'b0;
    do_reset();
    step(SUBCMD_DEEP_IDLE, 2, BPM_IDLE);
    step(SUBCMD_SHUTDOWN, 2, BPM_PD_WAIT);
    chk("switch blocks", 3'h3, {1'h0, discharge_switch_block, charge_switch_block});
    do_reset();
    low_voltage = 1'b1;
    step(16'h0000, 0, BPM_PD_WAIT);
    low_voltage = 1'b0;
    step(16'h0000, 0, BPM_PD_WAIT);
    step(SUBCMD_LEAVE_IDLE, 1, BPM_FULL);
    int_overtemp = 1'b1;
    step(16'h0000, 0, BPM_FULL);
    int_temp_cfg = 1'b1;
    step(16'h0000, 0, BPM_PD_WAIT);
    {int_overtemp, int_temp_cfg} = 2'h0;
    step(SUBCMD_RESET, 1, BPM_FULL);
    do_reset();
    overtemp_powerdown_cfg = 1'b1;
    hw_overtemp = 1'b1;
    step(16'h0000, 0, BPM_PD_WAIT);
    hw_overtemp = 1'b0;
    repeat (100) @(posedge ref_clk);
    #2 step(16'h0000, 0, BPM_OFF);
    $display("power-down tests done");
    conclude();
  end
endmodule : tb
